/* File: rtl/asw_host.sv */
// Host controller that drives the asynchronous word array over its pins.
`timescale 1ns/1ps
module asw_host
  import asw_pkg::*;
#(
  parameter int POWERUP_CYCLES = ASW_POWERUP_CYCLES
)
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic req_valid,
  input wire asw_req_type req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [ASW_DATA_W-1:0] rsp_data,
  output asw_ctrl_type mem_ctrl,
  output logic [ASW_DATA_W-1:0] mem_data_out,
  output logic [ASW_DATA_W-1:0] mem_data_oe,
  input wire logic [ASW_DATA_W-1:0] mem_data_in
);

  asw_state_type state_q;
  asw_state_type state_d;
  logic [ASW_CNT_W-1:0] cnt_q;
  logic [ASW_CNT_W-1:0] cnt_d;
  asw_ctrl_type ctrl_q;
  asw_ctrl_type ctrl_d;
  logic [ASW_DATA_W-1:0] dout_q;
  logic [ASW_DATA_W-1:0] dout_d;
  logic [ASW_DATA_W-1:0] doe_q;
  logic [ASW_DATA_W-1:0] doe_d;
  logic [ASW_DATA_W-1:0] rdata_q;
  logic [ASW_DATA_W-1:0] rdata_d;
  logic rsp_valid_q;
  logic rsp_valid_d;
  logic ready_q;
  logic ready_d;
  logic [ASW_DATA_W-1:0] din_meta_q;
  logic [ASW_DATA_W-1:0] din_sync_q;
  logic [1:0] lanes_q;
  logic [1:0] lanes_d;
  logic powered;

  // ----------------------------------------
  // Power-up wait
  // ----------------------------------------
  asw_powerup_timer #(
    .WAIT_CYCLES(POWERUP_CYCLES)
  ) u_powerup (
    .clock(clock),
    .sys_rst(sys_rst),
    .done(powered)
  );

  // ----------------------------------------
  // Read data synchroniser
  // ----------------------------------------
  always_ff @(posedge clock)
  begin
    din_meta_q <= mem_data_in;
    din_sync_q <= din_meta_q;
  end

  // ----------------------------------------
  // Access sequencer
  // ----------------------------------------
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    ctrl_d = ctrl_q;
    dout_d = dout_q;
    doe_d = doe_q;
    rdata_d = rdata_q;
    rsp_valid_d = 1'b0;
    ready_d = 1'b0;
    lanes_d = lanes_q;
    case (state_q)
      ASW_ST_POWERUP:
      begin
        if (powered)
        begin
          state_d = ASW_ST_IDLE;
          ready_d = 1'b1;
        end
      end
      ASW_ST_IDLE:
      begin
        ready_d = 1'b1;
        if (req_valid && ready_q)
        begin
          ready_d = 1'b0;
          // Address settles together with the select.
          ctrl_d.addr = req.addr;
          ctrl_d.select_active_low = 1'b0;
          ctrl_d.select_active_high = 1'b1;
          ctrl_d.low_lane_enable_n = ~req.lanes[0];
          ctrl_d.high_lane_enable_n = ~req.lanes[1];
          lanes_d = req.lanes;
          cnt_d = '0;
          if (req.write)
          begin
            // Output enable stays high so the device never drives.
            ctrl_d.output_enable_n = 1'b1;
            dout_d = req.wdata;
            state_d = ASW_ST_WSETUP;
          end
          else
          begin
            ctrl_d.output_enable_n = 1'b0;
            state_d = ASW_ST_READ;
          end
        end
      end
      ASW_ST_READ:
      begin
        cnt_d = cnt_q + 1'b1;
        // Sample after access time plus the synchroniser delay.
        if (cnt_q == ASW_CNT_W'(ASW_READ_CYCLES + 1))
        begin
          rdata_d = din_sync_q & {{ASW_LANE_W{lanes_q[1]}}, {ASW_LANE_W{lanes_q[0]}}};
          rsp_valid_d = 1'b1;
          ctrl_d.output_enable_n = 1'b1;
          ctrl_d.select_active_low = 1'b1;
          ctrl_d.select_active_high = 1'b0;
          cnt_d = '0;
          state_d = ASW_ST_WEND;
        end
      end
      ASW_ST_WSETUP:
      begin
        // Drive data only after the device outputs are off.
        doe_d = {{ASW_LANE_W{lanes_q[1]}}, {ASW_LANE_W{lanes_q[0]}}};
        ctrl_d.write_strobe_n = 1'b0;
        cnt_d = '0;
        state_d = ASW_ST_WPULSE;
      end
      ASW_ST_WPULSE:
      begin
        cnt_d = cnt_q + 1'b1;
        // Strobe width covers the minimum pulse and data setup.
        if (cnt_q == ASW_CNT_W'(ASW_WRITE_PULSE_CYCLES - 1))
        begin
          ctrl_d.write_strobe_n = 1'b1;
          cnt_d = '0;
          state_d = ASW_ST_WEND;
        end
      end
      ASW_ST_WEND:
      begin
        // Data held one cycle past the ending edge, then released.
        doe_d = '0;
        ctrl_d.select_active_low = 1'b1;
        ctrl_d.select_active_high = 1'b0;
        ctrl_d.low_lane_enable_n = 1'b1;
        ctrl_d.high_lane_enable_n = 1'b1;
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == ASW_CNT_W'(ASW_TURN_CYCLES))
        begin
          state_d = ASW_ST_IDLE;
          ready_d = 1'b1;
        end
      end
      default:
      begin
        state_d = ASW_ST_POWERUP;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      state_q <= ASW_ST_POWERUP;
      cnt_q <= '0;
      ctrl_q <= '{addr: '0, select_active_low: 1'b1, select_active_high: 1'b0,
        output_enable_n: 1'b1, write_strobe_n: 1'b1, low_lane_enable_n: 1'b1,
        high_lane_enable_n: 1'b1};
      dout_q <= 16'h0000;
      doe_q <= 16'h0000;
      rdata_q <= 16'h0000;
      rsp_valid_q <= 1'b0;
      ready_q <= 1'b0;
      lanes_q <= 2'b00;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      ctrl_q <= ctrl_d;
      dout_q <= dout_d;
      doe_q <= doe_d;
      rdata_q <= rdata_d;
      rsp_valid_q <= rsp_valid_d;
      ready_q <= ready_d;
      lanes_q <= lanes_d;
    end
  end

  assign req_ready = ready_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_data = rdata_q;
  assign mem_ctrl = ctrl_q;
  assign mem_data_out = dout_q;
  assign mem_data_oe = doe_q;

endmodule

/* File: rtl/asw_pkg.sv */
// Package with pin groups, states and timing constants for the word array host controller.
package asw_pkg;

  // ----------------------------------------
  // Array geometry
  // ----------------------------------------
  localparam int ASW_ADDR_W = 20;
  localparam int ASW_DATA_W = 16;
  localparam int ASW_LANE_W = 8;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int ASW_CLK_PERIOD_PS = 4000;
  localparam int ASW_POWERUP_WAIT_TIME_US = 1000;
  localparam int ASW_POWERUP_CYCLES = (ASW_POWERUP_WAIT_TIME_US * 1000000) / ASW_CLK_PERIOD_PS;
  localparam int ASW_READ_CYCLE_MIN_TIME_PS = 10000;
  localparam int ASW_WRITE_CYCLE_MIN_TIME_PS = 10000;
  localparam int ASW_WRITE_PULSE_MIN_WIDTH_PS = 7000;
  localparam int ASW_ADDRESS_ACCESS_TIME_PS = 10000;
  localparam int ASW_OE_TURNOFF_TIME_PS = 5000;
  localparam int ASW_DATA_SETUP_TIME_PS = 5500;
  localparam int ASW_READ_CYCLES =
    (ASW_ADDRESS_ACCESS_TIME_PS + ASW_CLK_PERIOD_PS - 1) / ASW_CLK_PERIOD_PS + 1;
  localparam int ASW_WRITE_PULSE_CYCLES =
    (ASW_WRITE_PULSE_MIN_WIDTH_PS + ASW_CLK_PERIOD_PS - 1) / ASW_CLK_PERIOD_PS;
  localparam int ASW_TURN_CYCLES =
    (ASW_OE_TURNOFF_TIME_PS + ASW_CLK_PERIOD_PS - 1) / ASW_CLK_PERIOD_PS;
  localparam int ASW_CNT_W = 8;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0]
  {
    ASW_ST_POWERUP = 3'b000,
    ASW_ST_IDLE = 3'b001,
    ASW_ST_READ = 3'b010,
    ASW_ST_WSETUP = 3'b011,
    ASW_ST_WPULSE = 3'b100,
    ASW_ST_WEND = 3'b101
  } asw_state_type;

  typedef struct packed
  {
    logic [ASW_ADDR_W-1:0] addr;
    logic select_active_low;
    logic select_active_high;
    logic output_enable_n;
    logic write_strobe_n;
    logic low_lane_enable_n;
    logic high_lane_enable_n;
  } asw_ctrl_type;

  typedef struct packed
  {
    logic write;
    logic [ASW_ADDR_W-1:0] addr;
    logic [ASW_DATA_W-1:0] wdata;
    logic [1:0] lanes;
  } asw_req_type;

endpackage

/* File: rtl/asw_powerup_timer.sv */
// Power-up wait counter that gates the first memory access.
`timescale 1ns/1ps
module asw_powerup_timer
  import asw_pkg::*;
#(
  parameter int WAIT_CYCLES = ASW_POWERUP_CYCLES
)
(
  input wire logic clock,
  input wire logic sys_rst,
  output logic done
);

  logic [31:0] count_q;
  logic [31:0] count_d;
  logic done_q;
  logic done_d;

  // ----------------------------------------
  // Wait counter
  // ----------------------------------------
  always_comb
  begin
    count_d = count_q;
    done_d = done_q;
    if (!done_q)
    begin
      if (count_q >= 32'(WAIT_CYCLES - 1))
      begin
        done_d = 1'b1;
      end
      else
      begin
        count_d = count_q + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      count_q <= 32'h0000_0000;
      done_q <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      done_q <= done_d;
    end
  end

  assign done = done_q;

endmodule

/* File: verif/asw_host_monitor.sv */
// Checker with the pin timing assertions of the word array host controller.
`timescale 1ns/1ps
module asw_host_monitor
  import asw_pkg::*;
#(
  parameter int POWERUP_CYCLES = ASW_POWERUP_CYCLES
)
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire asw_ctrl_type mem_ctrl,
  input wire logic [ASW_DATA_W-1:0] mem_data_out,
  input wire logic [ASW_DATA_W-1:0] mem_data_oe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic [31:0] pu_q;
  logic [31:0] pu_d;
  logic sel;
  logic [ASW_DATA_W-1:0] lane_mask;
  assign sel = !mem_ctrl.select_active_low && mem_ctrl.select_active_high;
  assign lane_mask = {{ASW_LANE_W{!mem_ctrl.high_lane_enable_n}},
    {ASW_LANE_W{!mem_ctrl.low_lane_enable_n}}};
  always_comb
  begin
    pu_d = pu_q;
    if (pu_q < POWERUP_CYCLES)
      pu_d = pu_q + 32'h0000_0001;
  end
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      pu_q <= 32'h0000_0000;
    else
      pu_q <= pu_d;
  end
  property p_powerup;
    (pu_q < POWERUP_CYCLES) |-> !sel && !req_ready;
  endproperty
  a_powerup: assert property (p_powerup) else $error("access during power-up wait");
  property p_no_fight;
    (mem_data_oe != 16'h0000) |-> mem_ctrl.output_enable_n;
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("host drives during read");
  property p_we_width;
    $fell(mem_ctrl.write_strobe_n) |-> !mem_ctrl.write_strobe_n [*2];
  endproperty
  a_we_width: assert property (p_we_width) else $error("write pulse too short");
  property p_data_hold;
    $rose(mem_ctrl.write_strobe_n) |-> mem_data_oe == lane_mask && $stable(mem_data_out);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("write data not held");
  property p_write_sel;
    !mem_ctrl.write_strobe_n |-> sel && mem_data_oe == lane_mask;
  endproperty
  a_write_sel: assert property (p_write_sel) else $error("strobe outside selection");
  property p_addr_stable;
    sel && $past(sel) |-> $stable(mem_ctrl.addr);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address moved in cycle");
  property p_read_len;
    $fell(mem_ctrl.output_enable_n) |-> !mem_ctrl.output_enable_n [*3];
  endproperty
  a_read_len: assert property (p_read_len) else $error("read cycle too short");
  property p_we_oe;
    !mem_ctrl.write_strobe_n |-> mem_ctrl.output_enable_n;
  endproperty
  a_we_oe: assert property (p_we_oe) else $error("output enabled in write");
  c_read: cover property (rsp_valid);
  c_write: cover property ($fell(mem_ctrl.write_strobe_n));
  c_nolane: cover property (!mem_ctrl.write_strobe_n && mem_ctrl.low_lane_enable_n);
endmodule
bind asw_host asw_host_monitor #(.POWERUP_CYCLES(POWERUP_CYCLES)) u_mon (.clock(clock),
  .sys_rst(sys_rst), .req_ready(req_ready), .rsp_valid(rsp_valid), .mem_ctrl(mem_ctrl),
  .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe));

/* File: verif/asw_sram_model.sv */
// Behavioural model of the asynchronous word array.
`timescale 1ns/1ps
module asw_sram_model
  import asw_pkg::*;
#(
  parameter int ACCESS_NS = 10
)
(
  input wire asw_ctrl_type ctrl,
  input wire logic [ASW_DATA_W-1:0] din,
  output logic [ASW_DATA_W-1:0] dout,
  output logic [ASW_DATA_W-1:0] doe
);
  logic [ASW_DATA_W-1:0] mem [0:(1 << ASW_ADDR_W) - 1];
  logic [ASW_DATA_W-1:0] word;
  logic [ASW_DATA_W-1:0] mask;
  logic [ASW_ADDR_W-1:0] addr_late;
  logic sel;
  logic rd_en;
  logic rd_late;
  assign sel = !ctrl.select_active_low && ctrl.select_active_high;
  assign mask = {{8{!ctrl.high_lane_enable_n}}, {8{!ctrl.low_lane_enable_n}}};
  assign word = mem[ctrl.addr];
  always @*
  begin
    if (sel && !ctrl.write_strobe_n && mask != 16'h0000)
      mem[ctrl.addr] = (word & ~mask) | (din & mask);
  end
  assign rd_en = sel && !ctrl.output_enable_n && ctrl.write_strobe_n;
  assign doe = rd_en ? mask : 16'h0000;
  assign #(ACCESS_NS) addr_late = ctrl.addr;
  assign #(ACCESS_NS) rd_late = rd_en;
  // Until the access time has run out the lines carry the inverse of the word.
  assign dout = (rd_en && rd_late && addr_late == ctrl.addr) ? word : ~word;
endmodule

/* File: verif/async_sram_word_array_tb.sv */
// Self-checking testbench of the word array host controller.
`timescale 1ns/1ps
module async_sram_word_array_tb
  import asw_pkg::*;
;
  localparam int PU = 20;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0;
  asw_req_type req = '0;
  logic req_ready;
  logic rsp_valid;
  logic [15:0] rsp_data;
  asw_ctrl_type mem_ctrl;
  logic [15:0] mem_data_out;
  logic [15:0] mem_data_oe;
  logic [15:0] mem_data_in;
  logic [15:0] dev_q;
  logic [15:0] dev_oe;
  logic [15:0] flt = 16'h5A5A;
  logic [15:0] q;
  int num_errors = 0;
  int samples_checked = 0;
  always #2 clock = ~clock;
  always @(posedge clock) flt <= ~flt;
  assign mem_data_in = (mem_data_oe & mem_data_out) | (~mem_data_oe & dev_oe & dev_q)
    | (~mem_data_oe & ~dev_oe & flt);
  asw_host #(.POWERUP_CYCLES(PU)) u_dut (.clock(clock), .sys_rst(sys_rst),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .mem_ctrl(mem_ctrl), .mem_data_out(mem_data_out),
    .mem_data_oe(mem_data_oe), .mem_data_in(mem_data_in));
  asw_sram_model u_mem (.ctrl(mem_ctrl), .din(mem_data_in), .dout(dev_q), .doe(dev_oe));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic xfer(input logic wr, input logic [19:0] a, input logic [15:0] d,
    input logic [1:0] ln, output logic [15:0] r);
    int n;
    n = 0;
    @(negedge clock);
    req_valid = 1'b1;
    req = '{write: wr, addr: a, wdata: d, lanes: ln};
    while (req_ready !== 1'b1 && n < 100)
    begin
      @(negedge clock);
      n++;
    end
    if (n >= 100)
    begin
      num_errors++;
      $display("MISMATCH req_ready expected 1 seen 0");
    end
    @(negedge clock);
    req_valid = 1'b0;
    n = 0;
    while (!wr && rsp_valid !== 1'b1 && n < 40)
    begin
      @(negedge clock);
      n++;
    end
    if (!wr && n >= 40)
    begin
      num_errors++;
      $display("MISMATCH rsp_valid expected 1 seen 0");
    end
    r = rsp_data;
  endtask
  task automatic t_powerup;
    repeat (PU - 2)
    begin
      @(negedge clock);
      chk("ready_wait", 16'h0000, {15'h0000, req_ready});
      chk("select_wait", 16'h0001, {15'h0000, mem_ctrl.select_active_low});
    end
  endtask
  task automatic t_lanes;
    xfer(1'b1, 20'h0_1234, 16'h1234, 2'b11, q);
    xfer(1'b1, 20'h0_1234, 16'hAAC5, 2'b01, q);
    xfer(1'b1, 20'h0_1234, 16'h7EBB, 2'b10, q);
    xfer(1'b0, 20'h0_1234, 16'h0000, 2'b11, q);
    chk("read_all", 16'h7EC5, q);
    xfer(1'b0, 20'h0_1234, 16'h0000, 2'b01, q);
    chk("read_low", 16'h00C5, q);
    xfer(1'b0, 20'h0_1234, 16'h0000, 2'b10, q);
    chk("read_high", 16'h7E00, q);
  endtask
  task automatic t_nolane;
    xfer(1'b1, 20'h0_1234, 16'hFFFF, 2'b00, q);
    xfer(1'b0, 20'h0_1234, 16'h0000, 2'b11, q);
    chk("no_lane_write", 16'h7EC5, q);
  endtask
  task automatic t_ends;
    xfer(1'b1, 20'hF_FFFF, 16'hBEEF, 2'b11, q);
    xfer(1'b1, 20'h0_0000, 16'h0F0F, 2'b11, q);
    repeat (50) @(negedge clock);
    xfer(1'b0, 20'hF_FFFF, 16'h0000, 2'b11, q);
    chk("top_word", 16'hBEEF, q);
    xfer(1'b0, 20'h0_0000, 16'h0000, 2'b11, q);
    chk("bottom_word", 16'h0F0F, q);
  endtask
  task automatic final_report;
    $display("Checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #20000;
    num_errors++;
    final_report();
  end
  initial
  begin
    repeat (8) @(negedge clock);
    sys_rst = 1'b0;
    t_powerup();
    t_lanes();
    t_nolane();
    t_ends();
    final_report();
  end
endmodule
